/* File: hw/pclk_divider.sv */
// Peripheral clock enable divider: full, half or quarter rate
`timescale 1ns/1ps
`include "pcr_params.svh"

module pclk_divider (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Control
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    // Tick
    output logic o_tick
);

    pcr_pkg::div_st_t s_q;
    pcr_pkg::div_st_t s_d;
    logic [1:0] lim;

    always_comb begin
        s_d = s_q;
        unique case (i_sel)
            `PCR_DIV_BY1: lim = 2'h0;
            `PCR_DIV_BY2: lim = 2'h1;
            default: lim = 2'h3;
        endcase
        if (!i_run) begin
            s_d.cnt = 2'h0;
            s_d.tick = 1'b0;
        end else if (s_q.cnt == 2'h0) begin
            s_d.cnt = lim;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 2'h1;
            s_d.tick = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;

endmodule // pclk_divider

/* File: hw/pcr_params.svh */
// Offsets, field positions, reset values and timing counts
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCR_OFS_MAP 8'h00
`define PCR_OFS_PWR 8'h04
`define PCR_OFS_PER_ON 8'h08
`define PCR_OFS_DIV 8'h0C
`define PCR_OFS_PLL 8'h10
`define PCR_OFS_WAKE 8'h14
`define PCR_OFS_STAT 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCR_PWR_IDLE 0
`define PCR_PWR_PD 1
`define PCR_PLL_EN 0
`define PCR_PLL_CON 1

// ----------------------------------------------------------------
// Divider codes and reset values
// ----------------------------------------------------------------
`define PCR_DIV_BY4 2'h0
`define PCR_DIV_BY1 2'h1
`define PCR_DIV_BY2 2'h2
`define PCR_RST_MAP 1'h0
`define PCR_RST_DIV 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCR_CLK_PERIOD_NS 100
`define PCR_WAKE_TIME_NS 6400
`define PCR_WAKE_CYC \
    ((`PCR_WAKE_TIME_NS + `PCR_CLK_PERIOD_NS - 1) / `PCR_CLK_PERIOD_NS)

`endif

/* File: hw/pcr_pkg.sv */
// Types shared by the power, clock and remap control block
package pcr_pkg;

    // ------------------------------------------------------------
    // Power mode states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_PDOWN,
        PM_WAKEUP
    } pm_state_t;

    // ------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } div_st_t;

endpackage

/* File: hw/pwr_clk_remap.sv */
// Power modes, clock gating, peripheral divider and vector remap
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "pcr_params.svh"

module pwr_clk_remap #(
    parameter int NPERIPH = 8,
    parameter int NEXT = 4,
    parameter int WAKE_CYC = `PCR_WAKE_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Wake sources and PLL lock
    input wire logic i_irq,
    input wire logic [NEXT-1:0] i_ext_irq,
    input wire logic i_pll_lock,
    // Vector remap, clock and power control
    output logic o_vec_sram,
    output logic o_core_run,
    output logic o_osc_en,
    output logic o_pll_en,
    output logic o_pll_sel,
    output logic o_pclk_tick,
    output logic [NPERIPH-1:0] o_periph_en,
    output logic o_pin_hold
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic map;
        pcr_pkg::pm_state_t pm;
        logic [NPERIPH-1:0] per_on;
        logic [1:0] div;
        logic pll_en;
        logic pll_con;
        logic [NEXT-1:0] wake_en;
        logic [7:0] wcnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [NEXT-1:0] ext_s1;
        logic [NEXT-1:0] ext_s2;
        logic lock_s1;
        logic lock_s2;
        logic core_run;
        logic osc_en;
        logic pll_run;
        logic pll_sel;
        logic [NPERIPH-1:0] per_en;
        logic pin_hold;
    } st_t;

    localparam logic [7:0] WAKE_LOAD = 8'(WAKE_CYC - 1);

    st_t s_q;
    st_t s_d;
    logic tick;
    logic acc;
    logic wr;
    logic [31:0] rd;
    logic hit;
    logic pd_wake;

    // ------------------------------------------------------------
    // Peripheral clock divider
    // ------------------------------------------------------------
    pclk_divider pclk_divider_i (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_run(s_q.osc_en),
        .i_sel(s_q.div),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        acc = i_psel && i_penable;
        wr = acc && i_pwrite && s_q.pready;
        hit = 1'b1;
        rd = 32'h0;
        unique case (i_paddr)
            `PCR_OFS_MAP: rd[0] = s_q.map;
            `PCR_OFS_PWR: begin
                rd[`PCR_PWR_IDLE] = (s_q.pm == pcr_pkg::PM_IDLE);
                rd[`PCR_PWR_PD] = (s_q.pm == pcr_pkg::PM_PDOWN);
            end
            `PCR_OFS_PER_ON: rd[NPERIPH-1:0] = s_q.per_on;
            `PCR_OFS_DIV: rd[1:0] = s_q.div;
            `PCR_OFS_PLL: begin
                rd[`PCR_PLL_EN] = s_q.pll_en;
                rd[`PCR_PLL_CON] = s_q.pll_con;
            end
            `PCR_OFS_WAKE: rd[NEXT-1:0] = s_q.wake_en;
            `PCR_OFS_STAT: begin
                rd[0] = s_q.lock_s2;
                rd[1] = s_q.pll_sel;
            end
            default: hit = 1'b0;
        endcase
        // Pin synchronisers
        s_d.ext_s1 = i_ext_irq;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.lock_s1 = i_pll_lock;
        s_d.lock_s2 = s_q.lock_s1;
        pd_wake = |(s_q.ext_s2 & s_q.wake_en);
        // Bus answer paced by peripheral clock
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (acc && !s_q.pready && tick) begin
            s_d.pready = 1'b1;
            s_d.pslverr = !hit;
            s_d.prdata = i_pwrite ? 32'h0 : rd;
        end
        // Register writes, state retained otherwise
        if (wr) begin
            unique case (i_paddr)
                `PCR_OFS_MAP: s_d.map = i_pwdata[0];
                `PCR_OFS_PER_ON: s_d.per_on = i_pwdata[NPERIPH-1:0];
                `PCR_OFS_DIV: s_d.div = i_pwdata[1:0];
                `PCR_OFS_PLL: begin
                    s_d.pll_en = i_pwdata[`PCR_PLL_EN];
                    s_d.pll_con = i_pwdata[`PCR_PLL_CON];
                end
                `PCR_OFS_WAKE: s_d.wake_en = i_pwdata[NEXT-1:0];
                default: ;
            endcase
        end
        // Power mode sequencing
        unique case (s_q.pm)
            pcr_pkg::PM_RUN: begin
                if (wr && i_paddr == `PCR_OFS_PWR) begin
                    if (i_pwdata[`PCR_PWR_PD]) begin
                        s_d.pm = pcr_pkg::PM_PDOWN;
                    end else if (i_pwdata[`PCR_PWR_IDLE]) begin
                        s_d.pm = pcr_pkg::PM_IDLE;
                    end
                end
            end
            pcr_pkg::PM_IDLE: begin
                if (i_irq) begin
                    s_d.pm = pcr_pkg::PM_RUN;
                end
            end
            pcr_pkg::PM_PDOWN: begin
                if (pd_wake) begin
                    s_d.pm = pcr_pkg::PM_WAKEUP;
                    s_d.wcnt = WAKE_LOAD;
                end
            end
            pcr_pkg::PM_WAKEUP: begin
                if (s_q.wcnt == 8'h0) begin
                    s_d.pm = pcr_pkg::PM_RUN;
                end else begin
                    s_d.wcnt = s_q.wcnt - 8'h1;
                end
            end
        endcase
        // Registered outputs from next mode
        s_d.core_run = (s_d.pm == pcr_pkg::PM_RUN);
        s_d.osc_en = (s_d.pm != pcr_pkg::PM_PDOWN);
        s_d.pll_run = s_d.pll_en && s_d.osc_en;
        s_d.pll_sel = s_d.pll_run && s_d.pll_con && s_q.lock_s2;
        s_d.per_en = s_d.osc_en ? s_d.per_on : '0;
        s_d.pin_hold = (s_d.pm == pcr_pkg::PM_PDOWN);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
            s_q.map <= `PCR_RST_MAP;
            s_q.pm <= pcr_pkg::PM_RUN;
            s_q.per_on <= '1;
            s_q.div <= `PCR_RST_DIV;
            s_q.pll_en <= 1'b0;
            s_q.pll_con <= 1'b0;
            s_q.core_run <= 1'b1;
            s_q.osc_en <= 1'b1;
            s_q.per_en <= '1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_pready = s_q.pready;
    assign o_prdata = s_q.prdata;
    assign o_pslverr = s_q.pslverr;
    assign o_vec_sram = s_q.map;
    assign o_core_run = s_q.core_run;
    assign o_osc_en = s_q.osc_en;
    assign o_pll_en = s_q.pll_run;
    assign o_pll_sel = s_q.pll_sel;
    assign o_pclk_tick = tick;
    assign o_periph_en = s_q.per_en;
    assign o_pin_hold = s_q.pin_hold;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence pd_enter;
        i_ce && s_q.pm == pcr_pkg::PM_RUN && wr &&
            i_paddr == `PCR_OFS_PWR && i_pwdata[`PCR_PWR_PD];
    endsequence

    sequence pd_woken;
        i_ce && s_q.pm == pcr_pkg::PM_PDOWN && pd_wake;
    endsequence

    a_vec_map_write: assert property (
        (i_ce && wr && i_paddr == `PCR_OFS_MAP)
            |=> o_vec_sram == $past(i_pwdata[0]))
        else $error("vector map did not follow write");

    a_idle_core_halt: assert property (
        (s_q.pm == pcr_pkg::PM_IDLE) |-> !o_core_run)
        else $error("core running in light sleep");

    a_idle_periph_run: assert property (
        (s_q.pm == pcr_pkg::PM_IDLE) |-> o_periph_en == s_q.per_on)
        else $error("peripherals gated in light sleep");

    a_pd_enter_clocks: assert property (
        pd_enter |=> !o_osc_en && o_periph_en == '0 && o_pin_hold)
        else $error("deep sleep did not stop clocks");

    a_pd_keep_regs: assert property (
        (s_q.pm == pcr_pkg::PM_PDOWN && !pd_wake)
            |=> $stable(s_q.per_on) && $stable(s_q.div) && $stable(s_q.map))
        else $error("state changed in deep sleep");

    a_pd_pin_hold: assert property (
        (s_q.pm == pcr_pkg::PM_PDOWN) |-> o_pin_hold && !o_core_run)
        else $error("pins not held in deep sleep");

    a_pd_wake_timer: assert property (
        pd_woken |=> (!o_core_run && o_osc_en) [*2])
        else $error("wake skipped the wake-up timer");

    a_pd_ext_wake: assert property (
        pd_woken |=> s_q.pm == pcr_pkg::PM_WAKEUP)
        else $error("enabled external interrupt did not wake");

    a_idle_pll_keep: assert property (
        (s_q.pm == pcr_pkg::PM_IDLE) |-> o_pll_en == s_q.pll_en)
        else $error("pll stopped in light sleep");

    a_idle_wake_clr: assert property (
        (i_ce && s_q.pm == pcr_pkg::PM_IDLE && i_irq)
            ##1 i_ce |=> o_core_run && s_q.pm == pcr_pkg::PM_RUN)
        else $error("sleep request not cleared on wake");

    a_bus_paced: assert property (
        $rose(o_pready) |-> $past(tick))
        else $error("bus answered off peripheral tick");

    a_pll_gate_off: assert property (
        !s_q.pll_en |-> !o_pll_en && !o_pll_sel)
        else $error("pll active while disabled");

    a_pd_tick_stop: assert property (
        (i_ce && !o_osc_en) |=> !o_pclk_tick)
        else $error("peripheral tick ran in deep sleep");

    a_wake_run_done: assert property (
        (i_ce && s_q.pm == pcr_pkg::PM_WAKEUP && s_q.wcnt == 8'h0)
            |=> o_core_run && s_q.pm == pcr_pkg::PM_RUN)
        else $error("wake-up did not return to run");

endmodule // pwr_clk_remap

/* File: tb/pwr_clk_remap_tb.sv */
// Self-checking bench for the power, clock and remap control block
`timescale 1ns/1ps
`include "pcr_params.svh"

`define CHK(a, e) begin \
    n_checks++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("unexpected at %0t: got %0h exp %0h", $time, (a), (e)); \
    end \
end

module pwr_clk_remap_tb;
    localparam int WK = 2;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_ce = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic i_irq = 1'b0;
    logic [3:0] i_ext_irq = 4'h0;
    logic i_pll_lock = 1'b0;
    logic o_pready, o_pslverr, o_vec_sram, o_core_run, o_osc_en;
    logic o_pll_en, o_pll_sel, o_pclk_tick, o_pin_hold;
    logic [31:0] o_prdata;
    logic [7:0] o_periph_en;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int n_checks = 0;
    int t;
    int n;

    always #50 i_clk = ~i_clk;

    pwr_clk_remap #(.NPERIPH(8), .NEXT(4), .WAKE_CYC(WK)) pwr_clk_remap_i (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
        .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_irq(i_irq),
        .i_ext_irq(i_ext_irq), .i_pll_lock(i_pll_lock),
        .o_vec_sram(o_vec_sram), .o_core_run(o_core_run),
        .o_osc_en(o_osc_en), .o_pll_en(o_pll_en), .o_pll_sel(o_pll_sel),
        .o_pclk_tick(o_pclk_tick), .o_periph_en(o_periph_en),
        .o_pin_hold(o_pin_hold)
    );

    // ------------------------------------------------------------
    // Bus and timing helpers
    // ------------------------------------------------------------
    task cyc(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task ticks();
        t = 0;
        repeat (8) begin
            @(posedge i_clk);
            if (o_pclk_tick === 1'b1) t++;
        end
    endtask

    task do_reset();
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        cyc(16);
        i_arst_n <= 1'b1;
        cyc(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset();
        `CHK(o_vec_sram, 1'b0)
        `CHK(o_pll_en, 1'b0)
        `CHK(o_pll_sel, 1'b0)
        `CHK(o_osc_en, 1'b1)
        apb(1'b0, `PCR_OFS_DIV, 32'h0);
        `CHK(rd[1:0], `PCR_RST_DIV)
        ticks();
        `CHK(t, 2)
        $display("test reset done");
    endtask

    task t_remap();
        apb(1'b1, `PCR_OFS_MAP, 32'h1);
        cyc(1);
        `CHK(o_vec_sram, 1'b1)
        apb(1'b1, `PCR_OFS_MAP, 32'h0);
        cyc(1);
        `CHK(o_vec_sram, 1'b0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        $display("test remap done");
    endtask

    task t_freeze();
        logic v;
        @(posedge i_clk);
        i_ce <= 1'b0;
        cyc(2);
        v = o_pclk_tick;
        ticks();
        `CHK(t, v ? 8 : 0)
        i_ce <= 1'b1;
        $display("test freeze done");
    endtask

    task t_div();
        logic [1:0] c;
        for (int k = 0; k < 4; k++) begin
            c = 2'((k + 1) % 4);
            apb(1'b1, `PCR_OFS_DIV, {30'h0, c});
            apb(1'b0, `PCR_OFS_DIV, 32'h0);
            `CHK(rd[1:0], c)
            ticks();
            `CHK(t, (c == 2'h1) ? 8 : (c == 2'h2) ? 4 : 2)
        end
        $display("test divider done");
    endtask

    task t_light();
        apb(1'b1, `PCR_OFS_PER_ON, 32'h5A);
        cyc(1);
        `CHK(o_periph_en, 8'h5A)
        i_pll_lock <= 1'b1;
        apb(1'b1, `PCR_OFS_PLL, 32'h3);
        cyc(4);
        `CHK(o_pll_sel, 1'b1)
        apb(1'b0, `PCR_OFS_STAT, 32'h0);
        `CHK(rd, 32'h3)
        apb(1'b1, `PCR_OFS_PWR, 32'h1);
        cyc(2);
        `CHK(o_core_run, 1'b0)
        `CHK(o_pll_en, 1'b1)
        `CHK(o_periph_en, 8'h5A)
        ticks();
        `CHK(t, 2)
        apb(1'b0, `PCR_OFS_PWR, 32'h0);
        `CHK(rd, 32'h1)
        i_irq <= 1'b1;
        @(posedge i_clk);
        i_irq <= 1'b0;
        cyc(2);
        `CHK(o_core_run, 1'b1)
        apb(1'b0, `PCR_OFS_PWR, 32'h0);
        `CHK(rd, 32'h0)
        $display("test light sleep done");
    endtask

    task t_deep();
        apb(1'b1, `PCR_OFS_WAKE, 32'h1);
        apb(1'b1, `PCR_OFS_PWR, 32'h3);
        cyc(2);
        `CHK(o_osc_en, 1'b0)
        `CHK(o_periph_en, 8'h00)
        `CHK(o_pin_hold, 1'b1)
        `CHK(o_core_run, 1'b0)
        `CHK(o_pll_en, 1'b0)
        `CHK(o_pll_sel, 1'b0)
        ticks();
        `CHK(t, 0)
        i_ext_irq <= 4'h2;
        cyc(8);
        `CHK(o_osc_en, 1'b0)
        `CHK(o_pin_hold, 1'b1)
        i_ext_irq <= 4'h1;
        n = 0;
        while (o_osc_en !== 1'b1 && n < 10) begin
            @(posedge i_clk);
            n++;
        end
        `CHK(o_core_run, 1'b0)
        `CHK(o_periph_en, 8'h5A)
        n = 0;
        while (o_core_run !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        `CHK(n >= WK && n < 20, 1'b1)
        i_ext_irq <= 4'h0;
        apb(1'b0, `PCR_OFS_PWR, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, `PCR_OFS_PER_ON, 32'h0);
        `CHK(rd, 32'h5A)
        $display("test deep sleep done");
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_reset();
        t_remap();
        t_freeze();
        t_div();
        t_light();
        t_deep();
        apb(1'b1, `PCR_OFS_DIV, 32'h1);
        do_reset();
        t_reset();
        print_verdict();
    end

    initial begin
        cyc(20000);
        failures++;
        print_verdict();
    end
endmodule // pwr_clk_remap_tb
